// >>> hw/ebp_pkg.sv
// Shared constants for the enhanced bridge PWM output stage
package ebp_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS  = 100;
  localparam int TOSC_PER_TCY   = 4;
  localparam int FINE_W         = 6;

  // Widths
  localparam int DUTY_W         = 10;
  localparam int TMR_W          = 8;
  localparam int DB_W           = 7;

  // Output configuration codes
  localparam logic [1:0] CFG_SINGLE   = 2'h0;
  localparam logic [1:0] CFG_FULL_FWD = 2'h1;
  localparam logic [1:0] CFG_HALF     = 2'h2;
  localparam logic [1:0] CFG_FULL_REV = 2'h3;
  localparam int CFG_DIR_BIT    = 1;
  localparam int CFG_FULL_BIT   = 0;

  // Prescale select codes and fine-count limits (Tosc per timer increment minus one)
  localparam logic [1:0]        PS_DIV1     = 2'h0;
  localparam logic [1:0]        PS_DIV4     = 2'h1;
  localparam logic [FINE_W-1:0] FINE_LAST1  = 6'h03;
  localparam logic [FINE_W-1:0] FINE_LAST4  = 6'h0F;
  localparam logic [FINE_W-1:0] FINE_LAST16 = 6'h3F;

  // Polarity field positions
  localparam int POL_BD_BIT     = 0;
  localparam int POL_AC_BIT     = 1;

  // Reset values
  localparam logic [DUTY_W-1:0] RST_DUTY  = 10'h000;
  localparam logic [TMR_W-1:0]  RST_TMR   = 8'h00;
  localparam logic [FINE_W-1:0] RST_FINE  = 6'h00;
  localparam logic [1:0]        RST_CFG   = 2'h0;

endpackage

// >>> hw/ebp_deadband.sv
// Turn-on delay of one half-bridge output, counted in instruction cycles
`timescale 1ns/1ps

module ebp_deadband #(
  parameter int DB_W = 7
) (
  // Clock, reset, enable
  input  wire logic            sys_clk,
  input  wire logic            rst,
  input  wire logic            ce,
  // Level and delay
  input  wire logic            level_in,
  input  wire logic [DB_W-1:0] delay_count,
  output logic                 level_out
);
  import ebp_pkg::*;

  logic [DB_W+1:0] cnt_q;
  logic [DB_W+1:0] limit;

  // Delay count is in instruction cycles of four Tosc each
  assign limit = {delay_count, 2'b00};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q     <= '0;
      level_out <= 1'b0;
    end else if (ce) begin
      if (!level_in) begin
        // Going inactive is never delayed
        cnt_q     <= '0;
        level_out <= 1'b0;
      end else if (!level_out) begin
        // A delay longer than the pulse leaves the output inactive all cycle
        if (cnt_q >= limit) begin
          level_out <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  db_release_a: assert property (@(posedge sys_clk) disable iff (rst)
    ce && !level_in |=> !level_out)
    else $error("dead band output not released with its input");

  db_wait_a: assert property (@(posedge sys_clk) disable iff (rst)
    ce && level_in && !level_out && (cnt_q < limit) |=> !level_out)
    else $error("dead band output went active before delay elapsed");

endmodule // ebp_deadband

// >>> hw/ebp_pwm.sv
// Enhanced PWM output stage: duty compare, output configurations, dead band, direction change
`timescale 1ns/1ps

// Functional notes
// - Duty is the upper duty byte joined with two low control bits.
// - Duty inputs change anytime; shadow takes them only at period match.
// - While PWM runs, software writes to the shadow duty are ignored.
// - Output clears when shadow duty equals timer plus two fine bits.
// - Duty beyond the period never clears the output in that period.
// - Two-bit field picks single, half-bridge, full forward or full reverse.
// - Half-bridge drives PWM on A and its complement on B.
// - Half-bridge delays each output's turn-on by the dead-band count.
// - Dead band longer than the pulse keeps that output inactive.
// - Forward: A active, D modulated, B and C inactive.
// - Reverse: C active, B modulated, A and D inactive.
// - A new direction takes effect from the next PWM cycle.
// - Direction change: last tick blanks modulated outputs and swaps static ones.
// - Swap interval is four Tosc times prescale: 4, 16 or 64 Tosc.
// - Full-bridge modes insert no dead band.
// - Period match clears timer, sets output unless duty zero, loads shadow.
// - Polarity field sets active level per A/C and B/D pair.
module ebp_pwm #(
  parameter int TMR_W = ebp_pkg::TMR_W,
  parameter int DB_W  = ebp_pkg::DB_W
) (
  // Clock, reset, enable
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  // Control
  input  wire logic                      pwm_enable,
  input  wire logic [1:0]                output_config_select,
  input  wire logic [1:0]                polarity_select,
  input  wire logic [1:0]                timer_prescale_select,
  input  wire logic [DB_W-1:0]           deadband_count,
  input  wire logic [TMR_W-1:0]          period_limit,
  // Duty
  input  wire logic [7:0]                duty_upper_byte,
  input  wire logic [1:0]                duty_low_bits,
  input  wire logic                      duty_shadow_wr,
  input  wire logic [ebp_pkg::DUTY_W-1:0] duty_shadow_wdata,
  // Status
  output logic [ebp_pkg::DUTY_W-1:0]     duty_shadow,
  output logic [TMR_W-1:0]               period_timer,
  output logic [1:0]                     config_active,
  // Bridge outputs
  output logic                           output_a,
  output logic                           output_b,
  output logic                           output_c,
  output logic                           output_d
);
  import ebp_pkg::*;

  if (TMR_W != 8) begin : g_chk_tmr
    $error("ebp_pwm: TMR_W must be 8 to pair with the 10-bit duty");
  end
  if (DB_W < 1 || DB_W > 8) begin : g_chk_db
    $error("ebp_pwm: DB_W must be 1 to 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescale decoding

  function automatic logic [FINE_W-1:0] fine_last(input logic [1:0] sel);
    if (sel == PS_DIV1) begin
      fine_last = FINE_LAST1;
    end else if (sel == PS_DIV4) begin
      fine_last = FINE_LAST4;
    end else begin
      fine_last = FINE_LAST16;
    end
  endfunction

  // Two compare bits below the timer: Q clock or the top prescaler bits
  function automatic logic [1:0] fine_ext(input logic [1:0] sel, input logic [FINE_W-1:0] f);
    if (sel == PS_DIV1) begin
      fine_ext = f[1:0];
    end else if (sel == PS_DIV4) begin
      fine_ext = f[3:2];
    end else begin
      fine_ext = f[5:4];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Signals

  logic [FINE_W-1:0] fine_q;
  logic [TMR_W-1:0]  tmr_q;
  logic [DUTY_W-1:0] shadow_q;
  logic [1:0]        cfg_q;
  logic              raw_q;
  logic [3:0]        pin_q;
  logic [DUTY_W-1:0] duty_req;
  logic              tick_end;
  logic              at_limit;
  logic              period_start;
  logic              cmp_hit;
  logic              dir_swap;
  logic [1:0]        db_in;
  logic [1:0]        db_out;
  logic [3:0]        act;
  logic [3:0]        pol_mask;

  assign duty_req     = {duty_upper_byte, duty_low_bits};
  // A tick lasts 4 Tosc times the prescale value
  assign tick_end     = fine_q >= fine_last(timer_prescale_select);
  assign at_limit     = tmr_q == period_limit;
  assign period_start = ce && tick_end && at_limit;
  // Timer never passes the limit, so an overlong duty finds no match
  assign cmp_hit      = {tmr_q, fine_ext(timer_prescale_select, fine_q)} == shadow_q;

  ////////////////////////////////////////////////////////////////////////////
  // Period timer with its fine Tosc count

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fine_q <= RST_FINE;
    end else if (ce) begin
      fine_q <= tick_end ? RST_FINE : fine_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tmr_q <= RST_TMR;
    end else if (ce && tick_end) begin
      tmr_q <= at_limit ? RST_TMR : tmr_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shadow duty and configuration, both double-buffered

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shadow_q <= RST_DUTY;
    end else if (period_start) begin
      shadow_q <= duty_req;
    end else if (ce && duty_shadow_wr && !pwm_enable) begin
      shadow_q <= duty_shadow_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_q <= RST_CFG;
    end else if (period_start) begin
      cfg_q <= output_config_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modulated waveform

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      raw_q <= 1'b0;
    end else if (period_start) begin
      raw_q <= duty_req != RST_DUTY;
    end else if (ce && cmp_hit) begin
      raw_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Half-bridge dead band, one delay per output

  // The direction bit is watched live, so a late write still gets its swap tick
  assign dir_swap = cfg_q[CFG_FULL_BIT] && output_config_select[CFG_FULL_BIT] &&
                    (output_config_select[CFG_DIR_BIT] != cfg_q[CFG_DIR_BIT]) && at_limit;

  always_comb begin
    db_in = 2'b00;
    if (pwm_enable && cfg_q == CFG_HALF) begin
      db_in = {~raw_q, raw_q};
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_db
    ebp_deadband #(
      .DB_W (DB_W)
    ) u_db (
      .sys_clk     (sys_clk),
      .rst         (rst),
      .ce          (ce),
      .level_in    (db_in[i]),
      .delay_count (deadband_count),
      .level_out   (db_out[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output steering, active level order {d, c, b, a}

  always_comb begin
    act = 4'h0;
    case (cfg_q)
      CFG_SINGLE: begin
        act[0] = raw_q;
      end
      CFG_HALF: begin
        act[1:0] = db_out;
      end
      CFG_FULL_FWD: begin
        act[0] = 1'b1;
        act[3] = raw_q;
      end
      default: begin
        act[2] = 1'b1;
        act[1] = raw_q;
      end
    endcase
    if (dir_swap) begin
      // Blank both modulated legs, then drive the static legs the new way
      act = 4'h0;
      act[0] = !output_config_select[CFG_DIR_BIT];
      act[2] = output_config_select[CFG_DIR_BIT];
    end
    if (!pwm_enable) begin
      act = 4'h0;
    end
  end

  assign pol_mask = {polarity_select[POL_BD_BIT], polarity_select[POL_AC_BIT],
                     polarity_select[POL_BD_BIT], polarity_select[POL_AC_BIT]};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_q <= 4'h0;
    end else if (ce) begin
      pin_q <= act ^ pol_mask;
    end
  end

  assign output_a      = pin_q[0];
  assign output_b      = pin_q[1];
  assign output_c      = pin_q[2];
  assign output_d      = pin_q[3];
  assign duty_shadow   = shadow_q;
  assign period_timer  = tmr_q;
  assign config_active = cfg_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_last_tick;
    ce && dir_swap && pwm_enable;
  endsequence

  shadow_load_a: assert property (@(posedge sys_clk) disable iff (rst)
    period_start |=> shadow_q == $past(duty_req))
    else $error("shadow duty not loaded at period match");

  shadow_lock_a: assert property (@(posedge sys_clk) disable iff (rst)
    !period_start && pwm_enable |=> $stable(shadow_q))
    else $error("shadow duty changed while PWM runs");

  duty_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    ce && cmp_hit && !period_start |=> !raw_q)
    else $error("modulated output not cleared on duty match");

  period_set_a: assert property (@(posedge sys_clk) disable iff (rst)
    period_start |=> (tmr_q == RST_TMR) && (raw_q == ($past(duty_req) != RST_DUTY)))
    else $error("period start did not clear timer or set output");

  fwd_drive_a: assert property (@(posedge sys_clk) disable iff (rst)
    ce && pwm_enable && cfg_q == CFG_FULL_FWD && !dir_swap |=>
      (output_a == !$past(polarity_select[POL_AC_BIT])) && (output_c == $past(polarity_select[POL_AC_BIT])) &&
      (output_b == $past(polarity_select[POL_BD_BIT])) &&
      (output_d == ($past(raw_q) ^ $past(polarity_select[POL_BD_BIT]))))
    else $error("forward full-bridge outputs wrong");

  rev_drive_a: assert property (@(posedge sys_clk) disable iff (rst)
    ce && pwm_enable && cfg_q == CFG_FULL_REV && !dir_swap |=>
      (output_c == !$past(polarity_select[POL_AC_BIT])) && (output_a == !output_c) &&
      (output_d == $past(polarity_select[POL_BD_BIT])) &&
      (output_b == ($past(raw_q) ^ $past(polarity_select[POL_BD_BIT]))))
    else $error("reverse full-bridge outputs wrong");

  swap_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
    s_last_tick |=> (output_b == $past(polarity_select[POL_BD_BIT])) &&
      (output_d == $past(polarity_select[POL_BD_BIT])) &&
      (output_a == ($past(output_config_select[CFG_DIR_BIT]) ^ !$past(polarity_select[POL_AC_BIT]))))
    else $error("modulated outputs active during direction swap");

  new_dir_a: assert property (@(posedge sys_clk) disable iff (rst)
    s_last_tick ##0 period_start |=> cfg_q == $past(output_config_select))
    else $error("new direction not applied at next period");

  half_comp_a: assert property (@(posedge sys_clk) disable iff (rst)
    ce && pwm_enable && cfg_q == CFG_HALF |-> !(db_out[0] && db_out[1]))
    else $error("half-bridge legs active together");

endmodule // ebp_pwm

// >>> test/ebp_bridge_model.sv
// Bridge driver model: counts cycles in which both switches of one leg are on
`timescale 1ns/1ps
module ebp_bridge_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Pins and their active levels
  input  wire logic       output_a,
  input  wire logic       output_b,
  input  wire logic       output_c,
  input  wire logic       output_d,
  input  wire logic [1:0] polarity_select,
  // Fault count
  output int              shoot_cnt
);
  logic [1:0] pol_q;
  logic       rst_q;
  // Pins are treated as driven at all times; the pin direction bits are taken as set
  always_ff @(posedge sys_clk) begin
    pol_q <= polarity_select;
    rst_q <= rst;
    // Pin latches read 0 in reset and on the edge after it, so those edges are not judged;
    // the count survives a mid-run reset so earlier faults are not lost
    if (!rst && !rst_q && (((output_a ^ pol_q[1]) && (output_b ^ pol_q[0])) ||
                        ((output_c ^ pol_q[1]) && (output_d ^ pol_q[0])))) shoot_cnt <= shoot_cnt + 1;
  end
endmodule // ebp_bridge_model

// >>> test/test_ebp_pwm.sv
// Self-checking bench for the enhanced bridge PWM output stage
`timescale 1ns/1ps
module test_ebp_pwm;
  import ebp_pkg::*;
  logic              sys_clk = 0, rst = 1, ce = 1, pwm_enable = 0, duty_shadow_wr = 0;
  logic [1:0]        output_config_select = 0, polarity_select = 0, timer_prescale_select = 0, duty_low_bits = 0;
  logic [DB_W-1:0]   deadband_count = 0;
  logic [TMR_W-1:0]  period_limit = 8'h03, period_timer;
  logic [7:0]        duty_upper_byte = 0;
  logic [DUTY_W-1:0] duty_shadow_wdata = 0, duty_shadow;
  logic [1:0]        config_active;
  logic              output_a, output_b, output_c, output_d;
  int                shoot_cnt, failures = 0, tests_run = 0;
  int                m_fine, m_tmr, m_sh, m_raw, m_cfg, m_pin;
  int                db_on[2], db_cnt[2];

  ebp_pwm dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .pwm_enable(pwm_enable),
    .output_config_select(output_config_select), .polarity_select(polarity_select),
    .timer_prescale_select(timer_prescale_select), .deadband_count(deadband_count), .period_limit(period_limit),
    .duty_upper_byte(duty_upper_byte), .duty_low_bits(duty_low_bits), .duty_shadow_wr(duty_shadow_wr),
    .duty_shadow_wdata(duty_shadow_wdata), .duty_shadow(duty_shadow), .period_timer(period_timer),
    .config_active(config_active), .output_a(output_a), .output_b(output_b), .output_c(output_c),
    .output_d(output_d));
  ebp_bridge_model bridge (.sys_clk(sys_clk), .rst(rst), .output_a(output_a), .output_b(output_b),
    .output_c(output_c), .output_d(output_d), .polarity_select(polarity_select), .shoot_cnt(shoot_cnt));

  always #(CLK_PERIOD_NS/2) sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Reference model; pin bits are a=8 b=4 c=2 d=1
  always @(posedge sys_clk) begin : model
    int ps, nf, nt, ext, act, tick;
    logic [1:0] s;
    if (rst) begin
      m_fine <= 0; m_tmr <= 0; m_sh <= 0; m_raw <= 0; m_cfg <= 0; m_pin <= 0;
      db_on <= '{0, 0}; db_cnt <= '{0, 0};
    end else if (ce) begin
      s = output_config_select;
      ps = timer_prescale_select == 2'h0 ? 1 : timer_prescale_select == 2'h1 ? 4 : 16;
      // A smaller prescale can leave the fine count past its last value; it then wraps at once
      tick = m_fine >= 4*ps-1;
      nf = tick ? 0 : m_fine + 1;
      nt = m_tmr;
      if (tick) begin
        nt = (m_tmr == period_limit) ? 0 : (m_tmr + 1) % 256;
      end
      ext = (m_fine >> (ps == 1 ? 0 : ps == 4 ? 2 : 4)) & 3;
      m_fine <= nf;
      m_tmr <= nt;
      if (tick && m_tmr == period_limit) begin
        m_sh <= {duty_upper_byte, duty_low_bits};
        m_cfg <= s;
        m_raw <= ({duty_upper_byte, duty_low_bits} != 0);
      end else begin
        if (duty_shadow_wr && !pwm_enable) m_sh <= duty_shadow_wdata;
        // The match is seen on the present count and clears on the following edge
        if (m_tmr*4 + ext == m_sh) m_raw <= 0;
      end
      // A leg that is already on stays on even if the delay is raised under it
      for (int i = 0; i < 2; i++) begin
        if (!(pwm_enable && m_cfg == CFG_HALF && m_raw == 1 - i)) begin
          db_on[i] <= 0;
          db_cnt[i] <= 0;
        end else if (!db_on[i]) begin
          if (db_cnt[i] >= 4*deadband_count) db_on[i] <= 1;
          else db_cnt[i] <= db_cnt[i] + 1;
        end
      end
      case (m_cfg)
        CFG_SINGLE: act = m_raw ? 8 : 0;
        CFG_HALF: act = (db_on[0] ? 8 : 0) | (db_on[1] ? 4 : 0);
        CFG_FULL_FWD: act = 8 | m_raw;
        default: act = 2 | (m_raw ? 4 : 0);
      endcase
      // Whole last timer tick before a reversal: static legs swap, modulated legs off
      if (m_cfg[0] && s[0] && s[1] != m_cfg[1] && m_tmr == period_limit) act = s[1] ? 2 : 8;
      m_pin <= (pwm_enable ? act : 0) ^ (polarity_select[1] ? 10 : 0) ^ (polarity_select[0] ? 5 : 0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("tests_run %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(negedge sys_clk) if (!rst) begin
    check(16'(period_timer), 16'(m_tmr));
    check(16'(duty_shadow), 16'(m_sh));
    check(16'(config_active), 16'(m_cfg));
    check(16'({output_a, output_b, output_c, output_d}), 16'(m_pin));
  end

  // Random shadow writes on about one cycle in eight, and clock-enable gaps only when jit is set
  task automatic step(input int n, input bit jit);
    repeat (n) begin
      @(negedge sys_clk);
      duty_shadow_wr = ($urandom % 8) == 0;
      duty_shadow_wdata = 10'($urandom);
      ce = jit ? ($urandom % 8) != 0 : 1'b1;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin : main
    logic [1:0] codes[8];
    int per, lim;
    codes = '{CFG_SINGLE, CFG_HALF, CFG_FULL_FWD, CFG_FULL_REV, CFG_FULL_FWD, CFG_HALF, CFG_FULL_REV, CFG_FULL_FWD};
    void'($urandom(70));
    repeat (12) @(negedge sys_clk);
    rst = 0;
    for (int i = 0; i < 16; i++) begin
      while (m_tmr != 0) step(1, 0);
      step(1, 0);
      lim = 1 + $urandom % 12;
      period_limit = 8'(lim);
      timer_prescale_select = 2'($urandom % 4);
      per = 4*(lim+1)*(timer_prescale_select == 2'h0 ? 1 : timer_prescale_select == 2'h1 ? 4 : 16);
      // Every third phase asks for a duty beyond the period, unless it reverses full-bridge direction and gets 10'h010
      {duty_upper_byte, duty_low_bits} = 10'((i%3 == 2) ? 4*(lim+1) + $urandom%8 : (i%5 == 4) ? 0 : $urandom%(4*lim+4));
      deadband_count = 7'($urandom % 6);
      polarity_select = 2'($urandom);
      pwm_enable = (i % 7) != 6;
      if (codes[i%8][0] && output_config_select[0] && codes[i%8][1] != output_config_select[1])
        {duty_upper_byte, duty_low_bits} = 10'h010;
      step($urandom % per, i % 2);
      output_config_select = codes[i%8];
      step(3*per, i % 2);
      if (i == 9) begin
        rst = 1;
        step(3, 0);
        rst = 0;
      end
    end
    check(16'(shoot_cnt), 16'h0000);
    end_of_test();
  end

  initial begin : watchdog
    #(90000*CLK_PERIOD_NS);
    failures++;
    end_of_test();
  end
endmodule // test_ebp_pwm
